/* logic/dccal_clk_gen.sv */
// calibration tick divider and pump clock output stage
`timescale 1ns/1ps
module dccal_clk_gen (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [2:0] divCode,
   input  wire logic       sdrMode,
   input  wire logic       outInvert,
   input  wire logic       outDisable,
   output logic            calTick,
   output logic            pumpClockOut,
   output logic            pumpClockOe
);
   import dccal_pkg::*;

   logic [DIV_BASE_LOG2-1:0] divCnt_q;
   logic [DIV_BASE_LOG2-1:0] divLast;
   logic                     halfPhase_q;
   logic                     baseClk;

   assign divLast = DIV_BASE_LOG2'((1 << (DIV_BASE_LOG2 - int'(divCode))) - 1);
   assign calTick = (divCnt_q >= divLast);

   always_ff @(posedge sys_clk) begin
      if (sys_rst || calTick) begin
         divCnt_q <= '0;
      end else begin
         divCnt_q <= divCnt_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         halfPhase_q <= 1'b0;
      end else begin
         halfPhase_q <= ~halfPhase_q;
      end
   end

   // full rate passes the clock itself; no flop can toggle at that rate
   assign baseClk      = sdrMode ? sys_clk : halfPhase_q;
   assign pumpClockOut = (baseClk ^ outInvert) & ~outDisable;
   assign pumpClockOe  = ~outDisable;
endmodule : dccal_clk_gen

/* logic/dccal_control.sv */
// register file, calibration and copy sequencing, sync options for the converter
`timescale 1ns/1ps
module dccal_control (
   input  wire logic                        sys_clk,
   input  wire logic                        sys_rst,
   input  wire logic [7:0]                  regAddr,
   input  wire logic [7:0]                  regWrData,
   input  wire logic                        regWrEn,
   input  wire logic                        regRdEn,
   output logic      [7:0]                  regRdData,
   input  wire logic [dccal_pkg::WORD_W-1:0] calibWordIn,
   input  wire logic [1:0]                  autoQuadrant,
   output logic      [1:0]                  quadrantApplied,
   output logic                             syncBypass,
   output logic                             calibBusy,
   output logic                             pumpClockOut,
   output logic                             pumpClockOe
);
   import dccal_pkg::*;

   dccal_trim_if trim ();

   dccal_state_e      state_q;
   logic [7:0]        outClk_q;
   logic [2:0]        trimDiv_q;
   logic [3:0]        lowBits_q;
   logic [ADDR_W-1:0] trimIndex_q;
   logic [WORD_W-1:0] trimValue_q;
   logic [7:0]        syncCfg_q;
   logic [1:0]        origin_q;
   logic              calibDone_q;
   logic              copyDone_q;
   logic [ADDR_W-1:0] stepIdx_q;
   logic [9:0]        tickCnt_q;
   logic [WORD_W-1:0] calibMeta_q;
   logic [WORD_W-1:0] calibSync_q;
   logic [1:0]        quadrant_q;
   logic              calTick;
   logic              softReset;
   logic              ctrlRst;
   logic              ctrlWrite;
   logic              calibStart;
   logic              copyStart;
   logic              stepDone;
   logic              lastStep;
   logic              calibFinish;
   logic              copyFinish;
   logic [9:0]        ticksPerWord;

   function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
      regHit = (a == off);
   endfunction : regHit

   // soft reset is a pulse, never stored, so it reads back as zero
   assign softReset = regWrEn && regHit(regAddr, REG_SOFT) && regWrData[SOFT_RESET_BIT];
   assign ctrlRst   = sys_rst || softReset;
   assign ctrlWrite = regWrEn && regHit(regAddr, REG_CTRL);

   // starts need the stored and the written low bits clear
   function automatic logic startAllowed(input logic [3:0] stored, input logic [3:0] written,
                                         input logic idle);
      startAllowed = idle && (stored == 4'h0) && (written == 4'h0);
   endfunction : startAllowed

   assign calibStart = ctrlWrite && regWrData[CALIB_START_BIT]
                       && startAllowed(lowBits_q, regWrData[3:0], !calibBusy);
   assign copyStart  = ctrlWrite && regWrData[COPY_START_BIT] && !regWrData[CALIB_START_BIT]
                       && startAllowed(lowBits_q, regWrData[3:0], !calibBusy);

   assign ticksPerWord = (state_q == ST_COPY) ? COPY_TICKS_PER_WORD : CALIB_TICKS_PER_WORD;
   assign stepDone     = calTick && (tickCnt_q == ticksPerWord - 10'd1);
   assign lastStep     = (stepIdx_q == ADDR_W'(DEPTH - 1));
   assign calibFinish  = (state_q == ST_CALIB) && stepDone && lastStep;
   assign copyFinish   = (state_q == ST_COPY) && stepDone && lastStep;
   assign calibBusy    = (state_q != ST_IDLE);

   // tick counter runs through a soft reset; only the hard reset restarts it
   dccal_clk_gen u_clk_gen (
      .sys_clk      (sys_clk),
      .sys_rst      (sys_rst),
      .divCode      (trimDiv_q),
      .sdrMode      (outClk_q[SDR_MODE_BIT]),
      .outInvert    (outClk_q[OUT_INV_BIT]),
      .outDisable   (outClk_q[OUT_DIS_BIT]),
      .calTick      (calTick),
      .pumpClockOut (pumpClockOut),
      .pumpClockOe  (pumpClockOe)
   );

   dccal_trim_store u_trim_store (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .trim    (trim)
   );

   // sequencer owns the memory ports while a cycle runs
   always_comb begin
      trim.forceDefault = lowBits_q[FORCE_DEF_BIT] && !calibBusy;
      trim.rdAddr       = calibBusy ? stepIdx_q : trimIndex_q;
      trim.wrAddr       = trimIndex_q;
      trim.wrData       = trimValue_q;
      trim.wrEn         = 1'b0;
      if (state_q == ST_CALIB) begin
         trim.wrAddr = stepIdx_q;
         trim.wrData = calibSync_q;
         trim.wrEn   = stepDone;
      end else if (state_q == ST_COPY) begin
         trim.wrAddr = stepIdx_q;
         trim.wrData = trim.rdFactory;
         trim.wrEn   = stepDone;
      end else begin
         trim.wrEn = lowBits_q[STORE_WR_BIT];
      end
   end

   // analog result arrives from outside this clock domain
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         calibMeta_q <= '0;
         calibSync_q <= '0;
      end else begin
         calibMeta_q <= calibWordIn;
         calibSync_q <= calibMeta_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (ctrlRst) begin
         state_q   <= ST_IDLE;
         stepIdx_q <= '0;
         tickCnt_q <= '0;
      end else begin
         // step index doubles as the memory address while a cycle runs
         unique case (state_q)
            ST_IDLE: begin
               stepIdx_q <= '0;
               tickCnt_q <= '0;
               if (calibStart) begin
                  state_q <= ST_CALIB;
               end else if (copyStart) begin
                  state_q <= ST_COPY;
               end
            end
            ST_CALIB, ST_COPY: begin
               if (stepDone) begin
                  tickCnt_q <= '0;
                  stepIdx_q <= stepIdx_q + 1'b1;
                  if (lastStep) begin
                     state_q <= ST_IDLE;
                  end
               end else if (calTick) begin
                  tickCnt_q <= tickCnt_q + 1'b1;
               end
            end
            default: begin
               state_q <= ST_IDLE; // unused code falls back to idle
            end
         endcase
      end
   end

   // completion flags: finishing beats a clearing start in the same cycle
   always_ff @(posedge sys_clk) begin
      if (ctrlRst) begin
         calibDone_q <= 1'b0;
         copyDone_q  <= 1'b0;
      end else begin
         if (calibFinish) begin
            calibDone_q <= 1'b1;
         end else if (calibStart || copyStart) begin
            calibDone_q <= 1'b0;
         end
         if (copyFinish) begin
            copyDone_q <= 1'b1;
         end else if (calibStart || copyStart) begin
            copyDone_q <= 1'b0;
         end
      end
   end

   // origin tracks whichever agent last wrote the static words, but a soft reset clears it to none and leaves the words
   // a forced fill beats a user write in the same cycle, as the store does
   always_ff @(posedge sys_clk) begin
      if (ctrlRst) begin
         origin_q <= ORIGIN_NONE;
      end else if (calibFinish) begin
         origin_q <= ORIGIN_SELF;
      end else if (copyFinish) begin
         origin_q <= ORIGIN_FACTORY;
      end else if (trim.forceDefault) begin
         origin_q <= ORIGIN_NONE;
      end else if (!calibBusy && lowBits_q[STORE_WR_BIT]) begin
         origin_q <= ORIGIN_USER;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (ctrlRst) begin
         lowBits_q <= 4'h0;
      end else if (ctrlWrite) begin
         lowBits_q <= regWrData[3:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (ctrlRst) begin
         outClk_q  <= OUTCLK_RESET;
         trimDiv_q <= DIV_RESET;
         syncCfg_q <= SYNC_RESET;
      end else if (regWrEn) begin
         if (regHit(regAddr, REG_OUTCLK)) begin
            outClk_q <= regWrData;
         end
         if (regHit(regAddr, REG_TRIMCFG)) begin
            trimDiv_q <= regWrData[2:0];
         end
         if (regHit(regAddr, REG_SYNC)) begin
            syncCfg_q <= {1'b0, regWrData[6:0]};
         end
      end
   end

   // index is never moved by the sequencer, so software keeps its place
   always_ff @(posedge sys_clk) begin
      if (ctrlRst) begin
         trimIndex_q <= '0;
      end else if (regWrEn && regHit(regAddr, REG_IDX)) begin
         trimIndex_q <= regWrData;
      end
   end

   // read-back overrides software writes so the field shows the memory
   always_ff @(posedge sys_clk) begin
      if (ctrlRst) begin
         trimValue_q <= '0;
      end else if (!calibBusy && lowBits_q[STORE_RD_BIT]) begin
         trimValue_q <= trim.rdStatic;
      end else if (!calibBusy && lowBits_q[FACTORY_RD_BIT]) begin
         trimValue_q <= trim.rdFactory;
      end else if (regWrEn && regHit(regAddr, REG_VAL)) begin
         trimValue_q <= regWrData[WORD_W-1:0];
      end
   end

   // quadrant choice; auto value comes from sync logic on this clock
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         quadrant_q <= 2'h0;
      end else if (syncCfg_q[QEXT_BIT]) begin
         quadrant_q <= syncCfg_q[QSEL_LSB +: 2];
      end else begin
         quadrant_q <= autoQuadrant;
      end
   end

   assign quadrantApplied = quadrant_q;
   assign syncBypass      = syncCfg_q[BYPASS_BIT];

   // registered read data: valid the edge after the strobe, held until the next read
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         regRdData <= 8'h00;
      end else if (regRdEn) begin
         unique case (regAddr)
            REG_OUTCLK:  regRdData <= outClk_q;
            REG_TRIMCFG: regRdData <= {2'h0, origin_q, 1'b0, trimDiv_q};
            REG_CTRL:    regRdData <= {calibDone_q, (state_q == ST_CALIB), copyDone_q,
                                       (state_q == ST_COPY), lowBits_q};
            REG_IDX:     regRdData <= trimIndex_q;
            REG_VAL:     regRdData <= {2'h0, trimValue_q};
            REG_QNOW:    regRdData <= {6'h00, quadrant_q};
            REG_SYNC:    regRdData <= syncCfg_q;
            default:     regRdData <= 8'h00;
         endcase
      end
   end
endmodule : dccal_control

/* logic/dccal_pkg.sv */
// shared constants, register map and state type for the trim memory and sync control block
package dccal_pkg;
   localparam int ADDR_W = 8;
   localparam int WORD_W = 6;
   localparam int DEPTH  = 256;

   // register offsets
   localparam logic [7:0] REG_SOFT    = 8'h00;
   localparam logic [7:0] REG_OUTCLK  = 8'h02;
   localparam logic [7:0] REG_TRIMCFG = 8'h0e;
   localparam logic [7:0] REG_CTRL    = 8'h0f;
   localparam logic [7:0] REG_IDX     = 8'h10;
   localparam logic [7:0] REG_VAL     = 8'h11;
   localparam logic [7:0] REG_QNOW    = 8'h15;
   localparam logic [7:0] REG_SYNC    = 8'h16;

   // field positions
   localparam int SOFT_RESET_BIT   = 7;
   localparam int SDR_MODE_BIT     = 7;
   localparam int OUT_INV_BIT      = 4;
   localparam int OUT_DIS_BIT      = 3;
   localparam int ORIGIN_LSB       = 4;
   localparam int CALIB_DONE_BIT   = 7;
   localparam int CALIB_START_BIT  = 6;
   localparam int COPY_DONE_BIT    = 5;
   localparam int COPY_START_BIT   = 4;
   localparam int STORE_WR_BIT     = 3;
   localparam int STORE_RD_BIT     = 2;
   localparam int FACTORY_RD_BIT   = 1;
   localparam int FORCE_DEF_BIT    = 0;
   localparam int BYPASS_BIT       = 6;
   localparam int QEXT_BIT         = 5;
   localparam int QSEL_LSB         = 3;

   // reset values
   localparam logic [7:0]        OUTCLK_RESET  = 8'h00;
   localparam logic [2:0]        DIV_RESET     = 3'h0;
   localparam logic [7:0]        SYNC_RESET    = 8'h00;
   localparam logic [WORD_W-1:0] TRIM_DEFAULT  = 6'h3f;

   // trim origin codes
   localparam logic [1:0] ORIGIN_NONE    = 2'h0;
   localparam logic [1:0] ORIGIN_SELF    = 2'h1;
   localparam logic [1:0] ORIGIN_FACTORY = 2'h2;
   localparam logic [1:0] ORIGIN_USER    = 2'h3;

   // divider: 4096 at code 0, halving per step
   localparam int DIV_BASE_LOG2 = 12;

   // cycle timing at the reference rate with the slowest divider
   localparam int CALIB_TIME_MS   = 100;
   localparam int COPY_TIME_MS    = 15;
   localparam int REF_CLK_KHZ     = 100000;
   localparam int REF_DIV         = 4096;
   localparam int CALIB_TICKS     = CALIB_TIME_MS * REF_CLK_KHZ / REF_DIV;
   localparam int COPY_TICKS      = COPY_TIME_MS * REF_CLK_KHZ / REF_DIV;
   localparam logic [9:0] CALIB_TICKS_PER_WORD = 10'(CALIB_TICKS / DEPTH);
   localparam logic [9:0] COPY_TICKS_PER_WORD  =
      10'((COPY_TICKS / DEPTH) > 0 ? COPY_TICKS / DEPTH : 1);

   typedef enum logic [1:0] {ST_IDLE, ST_CALIB, ST_COPY} dccal_state_e;
endpackage : dccal_pkg

/* logic/dccal_trim_if.sv */
// port bundle between the control logic and the trim memories
`timescale 1ns/1ps
interface dccal_trim_if;
   import dccal_pkg::*;
   logic              wrEn;
   logic [ADDR_W-1:0] wrAddr;
   logic [WORD_W-1:0] wrData;
   logic              forceDefault;
   logic [ADDR_W-1:0] rdAddr;
   logic [WORD_W-1:0] rdStatic;
   logic [WORD_W-1:0] rdFactory;

   modport ctrl  (output wrEn, wrAddr, wrData, forceDefault, rdAddr,
                  input rdStatic, rdFactory);
   modport store (input wrEn, wrAddr, wrData, forceDefault, rdAddr,
                  output rdStatic, rdFactory);
endinterface : dccal_trim_if

/* logic/dccal_trim_store.sv */
// static trim memory and fixed factory trim table
`timescale 1ns/1ps
module dccal_trim_store (
   input wire logic sys_clk,
   input wire logic sys_rst,
   dccal_trim_if.store trim
);
   import dccal_pkg::*;

   logic [WORD_W-1:0] storeMem [DEPTH];

   // factory values are fixed; pattern is arbitrary
   function automatic logic [WORD_W-1:0] factoryWord(input logic [ADDR_W-1:0] a);
      factoryWord = 6'h20 + {3'h0, a[2:0]};
   endfunction : factoryWord

   // whole-array fill so forcing defaults takes one cycle
   always_ff @(posedge sys_clk) begin
      if (sys_rst || trim.forceDefault) begin
         for (int i = 0; i < DEPTH; i++) begin
            storeMem[i] <= TRIM_DEFAULT;
         end
      end else if (trim.wrEn) begin
         storeMem[trim.wrAddr] <= trim.wrData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         trim.rdStatic <= TRIM_DEFAULT;
      end else begin
         trim.rdStatic <= storeMem[trim.rdAddr];
      end
   end

   assign trim.rdFactory = factoryWord(trim.rdAddr);
endmodule : dccal_trim_store

/* sim/dccal_control_bench.sv */
// self-checking bench for the trim memory and sync control block
`timescale 1ns/1ps
module dccal_control_bench;
   import dccal_pkg::*;
   logic              sys_clk      = 1'b0;
   logic              sys_rst      = 1'b1;
   logic [7:0]        regAddr      = 8'h00;
   logic [7:0]        regWrData    = 8'h00;
   logic              regWrEn      = 1'b0;
   logic              regRdEn      = 1'b0;
   logic [WORD_W-1:0] calibWordIn  = 6'h00;
   logic [1:0]        autoQuadrant = 2'h0;
   logic [7:0]        regRdData;
   logic [1:0]        quadrantApplied;
   logic              syncBypass, calibBusy, pumpClockOut, pumpClockOe;
   int                pumpEdges;
   int                errors = 0;
   int                totalChecks = 0;

   dccal_control DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .calibWordIn(calibWordIn), .autoQuadrant(autoQuadrant),
      .quadrantApplied(quadrantApplied), .syncBypass(syncBypass), .calibBusy(calibBusy),
      .pumpClockOut(pumpClockOut), .pumpClockOe(pumpClockOe));
   dccal_pump_model pump (.pumpClockOut(pumpClockOut), .pumpClockOe(pumpClockOe),
      .edgeCount(pumpEdges));

   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", totalChecks, errors);
      if (errors == 0 && totalChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge sys_clk);
      regWrEn   <= 1'b0;
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge sys_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      #1 chk(e, regRdData & m);
   endtask : rdchk

   task automatic static_chk(input logic [7:0] idx, input logic [7:0] e);
      wr(REG_IDX, idx);
      wr(REG_CTRL, 8'h04);
      repeat (3) @(posedge sys_clk);
      rdchk(REG_VAL, 8'h3f, e);
      wr(REG_CTRL, 8'h00);
   endtask : static_chk

   // bounded wait for the sequencer to go idle
   task automatic wait_idle(input int bound, output int n);
      n = 0;
      while (calibBusy !== 1'b0 && n < bound) begin
         @(posedge sys_clk);
         #1 n++;
      end
      if (n >= bound) begin
         errors++;
         $display("CHECK FAILED at %0t: busy wait expired, expected %h got %h", $time, 0, 1);
         close_out();
      end
   endtask : wait_idle

   task automatic t_regs;
      rdchk(REG_IDX, 8'hff, 8'h00);
      rdchk(REG_VAL, 8'hff, 8'h00);
      wr(REG_IDX, 8'ha5);
      wr(REG_VAL, 8'hea);
      wr(REG_QNOW, 8'h03);
      wr(8'h33, 8'h5a);
      rdchk(REG_IDX, 8'hff, 8'ha5);
      rdchk(REG_VAL, 8'hff, 8'h2a);
      rdchk(REG_QNOW, 8'hff, 8'h00);
      rdchk(8'h33, 8'hff, 8'h00);
      $display("test regs done");
   endtask : t_regs

   task automatic t_sync;
      @(posedge sys_clk);
      autoQuadrant <= 2'h1;
      wr(REG_SYNC, 8'hf0);
      repeat (2) @(posedge sys_clk);
      #1 chk(2'h2, quadrantApplied);
      chk(1'b1, syncBypass);
      rdchk(REG_SYNC, 8'hff, 8'h70);
      rdchk(REG_QNOW, 8'hff, 8'h02);
      wr(REG_SYNC, 8'h00);
      repeat (2) @(posedge sys_clk);
      #1 chk(2'h1, quadrantApplied);
      chk(1'b0, syncBypass);
      $display("test sync done");
   endtask : t_sync

   task automatic t_clock;
      logic [31:0] modes = 32'h10908000;
      logic [7:0]  m;
      int          c0;
      int          e;
      for (int i = 0; i < 4; i++) begin
         m = modes[8*i +: 8];
         e = m[7] ? 40 : 20;
         wr(REG_OUTCLK, m);
         repeat (4) @(negedge sys_clk);
         c0 = pumpEdges;
         repeat (40) @(negedge sys_clk);
         chk(1'b1, (pumpEdges - c0 >= e - 1) && (pumpEdges - c0 <= e + 1));
         #1 if (m[7]) chk(m[4], pumpClockOut);
      end
      wr(REG_OUTCLK, 8'h08);
      @(posedge sys_clk);
      #1 chk(1'b0, pumpClockOe);
      rdchk(REG_OUTCLK, 8'hff, 8'h08);
      wr(REG_OUTCLK, 8'h00);
      @(posedge sys_clk);
      #1 chk(1'b1, pumpClockOe);
      $display("test clock done");
   endtask : t_clock

   task automatic t_indirect;
      wr(REG_IDX, 8'h05);
      wr(REG_VAL, 8'h15);
      wr(REG_CTRL, 8'h08);
      wr(REG_CTRL, 8'h00);
      rdchk(REG_TRIMCFG, 8'h30, 8'h30);
      wr(REG_VAL, 8'h00);
      static_chk(8'h05, 8'h15);
      wr(REG_IDX, 8'h03);
      wr(REG_CTRL, 8'h02);
      repeat (3) @(posedge sys_clk);
      rdchk(REG_VAL, 8'h3f, 8'h23);
      wr(REG_CTRL, 8'h01);
      repeat (4) @(posedge sys_clk);
      rdchk(REG_CTRL, 8'hff, 8'h01);
      rdchk(REG_TRIMCFG, 8'h30, 8'h00);
      static_chk(8'h05, 8'h3f);
      $display("test indirect done");
   endtask : t_indirect

   task automatic t_refuse;
      wr(REG_CTRL, 8'h01);
      wr(REG_CTRL, 8'h40);
      #1 chk(1'b0, calibBusy);
      rdchk(REG_CTRL, 8'hff, 8'h00);
      wr(REG_CTRL, 8'h11);
      #1 chk(1'b0, calibBusy);
      wr(REG_CTRL, 8'h00);
      $display("test refuse done");
   endtask : t_refuse

   task automatic t_copy;
      int n;
      wr(REG_TRIMCFG, 8'h07);
      rdchk(REG_TRIMCFG, 8'h07, 8'h07);
      wr(REG_CTRL, 8'h10);
      rdchk(REG_CTRL, 8'hf0, 8'h10);
      wait_idle(20000, n);
      chk(1'b1, n > 8100 && n < 8300);
      rdchk(REG_CTRL, 8'hff, 8'h20);
      rdchk(REG_TRIMCFG, 8'h37, 8'h27);
      static_chk(8'h03, 8'h23);
      $display("test copy done");
   endtask : t_copy

   task automatic t_calib;
      int n;
      @(posedge sys_clk);
      calibWordIn <= 6'h2b;
      wr(REG_CTRL, 8'h40);
      #1 chk(1'b1, calibBusy);
      wait_idle(80000, n);
      chk(1'b1, n > 73000 && n < 74500);
      rdchk(REG_CTRL, 8'hff, 8'h80);
      rdchk(REG_TRIMCFG, 8'h30, 8'h10);
      static_chk(8'h03, 8'h2b);
      wr(REG_CTRL, 8'h10);
      rdchk(REG_CTRL, 8'hf0, 8'h10);
      wr(REG_SOFT, 8'h80);
      #1 chk(1'b0, calibBusy);
      rdchk(REG_SOFT, 8'hff, 8'h00);
      rdchk(REG_TRIMCFG, 8'hff, 8'h00);
      static_chk(8'h03, 8'h2b);
      $display("test calib done");
   endtask : t_calib

   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_sync();
      t_clock();
      t_indirect();
      t_refuse();
      t_copy();
      t_calib();
      close_out();
   end
endmodule : dccal_control_bench

/* sim/dccal_control_chk.sv */
// concurrent checks on the trim memory and sync control top ports
`timescale 1ns/1ps
module dccal_control_chk
   import dccal_pkg::*;
(
   input wire logic                         sys_clk,
   input wire logic                         sys_rst,
   input wire logic [7:0]                   regAddr,
   input wire logic [7:0]                   regWrData,
   input wire logic                         regWrEn,
   input wire logic                         regRdEn,
   input wire logic [7:0]                   regRdData,
   input wire logic [dccal_pkg::WORD_W-1:0] calibWordIn,
   input wire logic [1:0]                   autoQuadrant,
   input wire logic [1:0]                   quadrantApplied,
   input wire logic                         syncBypass,
   input wire logic                         calibBusy,
   input wire logic                         pumpClockOut,
   input wire logic                         pumpClockOe
);
   logic       sdrMode_q;
   logic       extEn_q;
   logic [1:0] selQuad_q;
   logic [3:0] lowBits_q;
   logic [31:0] busyCnt_q;
   wire logic       softHit = regWrEn && regAddr == REG_SOFT && regWrData[SOFT_RESET_BIT];
   wire logic       cfgHit  = softHit || (regWrEn && regAddr == REG_OUTCLK);
   wire logic       ctlWr   = regWrEn && regAddr == REG_CTRL;
   wire logic       wrDis   = regWrData[OUT_DIS_BIT];
   wire logic       wrByp   = regWrData[BYPASS_BIT];
   wire logic       wrStart = regWrData[CALIB_START_BIT] || regWrData[COPY_START_BIT];
   wire logic [1:0] quadSrc = extEn_q ? selQuad_q : autoQuadrant;

   // mirror of the configuration the assertions depend on
   always_ff @(posedge sys_clk) begin
      if (sys_rst || softHit) begin
         sdrMode_q <= 1'b0;
         extEn_q   <= 1'b0;
         selQuad_q <= 2'h0;
         lowBits_q <= 4'h0;
      end else if (regWrEn) begin
         if (regAddr == REG_OUTCLK) sdrMode_q <= regWrData[SDR_MODE_BIT];
         if (regAddr == REG_SYNC) extEn_q <= regWrData[QEXT_BIT];
         if (regAddr == REG_SYNC) selQuad_q <= regWrData[QSEL_LSB +: 2];
         if (regAddr == REG_CTRL) lowBits_q <= regWrData[3:0];
      end
   end

   // length of the current busy stretch
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !calibBusy) busyCnt_q <= 32'h0;
      else busyCnt_q <= busyCnt_q + 32'h1;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_oe_from_reg: assert property (
      regWrEn && regAddr == REG_OUTCLK |=> pumpClockOe == !$past(wrDis))
      else $error("pump clock enable does not follow its disable bit");
   a_off_stays_low: assert property (!pumpClockOe |-> !pumpClockOut)
      else $error("pump clock moves while its driver is off");
   a_bypass_follows: assert property (
      regWrEn && regAddr == REG_SYNC |=> syncBypass == $past(wrByp))
      else $error("bypass output does not follow its bit");
   a_quad_source: assert property (
      !$past(sys_rst) |-> quadrantApplied == $past(quadSrc))
      else $error("applied quadrant is not the selected source");
   a_quad_readback: assert property (
      regRdEn && regAddr == REG_QNOW |=> regRdData == {6'h00, $past(quadrantApplied)})
      else $error("quadrant status read differs from quadrant in use");
   a_start_taken: assert property (
      ctlWr && wrStart && regWrData[3:0] == 4'h0 && lowBits_q == 4'h0 && !calibBusy
      |=> calibBusy)
      else $error("legal start did not launch a cycle");
   a_start_refused: assert property (
      ctlWr && (regWrData[3:0] != 4'h0 || lowBits_q != 4'h0) && !calibBusy |=> !calibBusy)
      else $error("start accepted with low control bits set");
   a_ddr_half_rate: assert property (
      !sdrMode_q && pumpClockOe && $past(pumpClockOe) && !$past(sys_rst) && !$past(sys_rst, 2)
      && !$past(cfgHit) && !$past(cfgHit, 2) |-> pumpClockOut != $past(pumpClockOut))
      else $error("pump clock not toggling each cycle in double rate mode");
   a_cycle_min_span: assert property (
      $fell(calibBusy) && !$past(softHit) && !$past(sys_rst) |-> busyCnt_q >= 32'd8000)
      else $error("calibration or copy cycle ended too early");
endmodule : dccal_control_chk

bind dccal_control dccal_control_chk chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
   .regRdData(regRdData), .calibWordIn(calibWordIn), .autoQuadrant(autoQuadrant),
   .quadrantApplied(quadrantApplied), .syncBypass(syncBypass), .calibBusy(calibBusy),
   .pumpClockOut(pumpClockOut), .pumpClockOe(pumpClockOe));

/* sim/dccal_pump_model.sv */
// data pump receiver model counting the rising clock edges it is given
`timescale 1ns/1ps
module dccal_pump_model (
   input  wire logic pumpClockOut,
   input  wire logic pumpClockOe,
   output int        edgeCount
);
   initial edgeCount = 0;
   // an undriven pair carries no clock, so only enabled edges count
   always @(posedge pumpClockOut) begin
      if (pumpClockOe === 1'b1) edgeCount <= edgeCount + 1;
   end
endmodule : dccal_pump_model
